// >>> shared/gpio_special_pkg.sv
// Constants and types for the general-pin special-function block
//
// Notes on behaviour
// R01 - Fifth and sixth general pins can serve as fault_out_a and fault_out_b.
// R02 - A fault output asserts when any selected channel violates any enabled type.
// R03 - fault_out_a selects channels 1-8 in its first register, 9-12 in second bits 3:0.
// R04 - Second register bits 4,5,6 enable overvoltage, undervoltage, early warning.
// R05 - Bit 7 of each second register: 0 active-low, 1 active-high.
// R06 - fault_out_b uses the same layout in its own third and fourth registers.
// R07 - Sixth pin as powerup_fault_out flags power-up fault, drops enables, saves log.
// R08 - trim_up_in low selects margin-up set; trim_down_in low selects margin-down set.
// R09 - Equal trim input levels select the normal DAC value registers.
// R10 - Margin-up or margin-down closes DAC switches and enables margin by itself.
// R11 - Without margin direction, DAC switches follow the DAC enable registers only.
// R12 - Margin enabled by trim_hold_in low or margin register control bit 1.
// R13 - While margining, hold fault and reset outputs, ignore violations, log nothing.
// R14 - Controller drives trim_hold_in low before moving supplies, high for normal use.
// R15 - manual_reset_in low asserts reset; reset holds for timeout after release. Here RESET_HOLD ends the cycle after release, with a RESET_START pulse.
// R16 - Sixth pin config 110 makes open-drain active-low watchdog_expired_out.
// R17 - Fifth pin config 111 makes watchdog_kick_in.
// R18 - With no enabled violation each fault output sits at its inactive level.
package gpio_special_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_FAULT_A_SEL = 8'h15;
  localparam logic [7:0] OFS_FAULT_A_CFG = 8'h16;
  localparam logic [7:0] OFS_FAULT_B_SEL = 8'h17;
  localparam logic [7:0] OFS_FAULT_B_CFG = 8'h18;

  // ==========================================================
  // Field positions
  localparam int CFG_HIGH_CH_MSB = 3;
  localparam int CFG_OV_BIT = 4;
  localparam int CFG_UV_BIT = 5;
  localparam int CFG_EW_BIT = 6;
  localparam int CFG_POL_BIT = 7;
  localparam int MARGIN_CTRL_BIT = 1;
  localparam int NUM_CH = 12;
  localparam int NUM_DAC = 12;

  // ==========================================================
  // Pin mode codes and reset values
  localparam logic [2:0] MODE_FAULT_PP = 3'h3;
  localparam logic [2:0] MODE_FAULT_OD = 3'h4;
  localparam logic [2:0] MODE_PIN6_MARGIN = 3'h0;
  localparam logic [2:0] MODE_PIN6_WDOG = 3'h6;
  localparam logic [2:0] MODE_SPECIAL = 3'h7;
  localparam logic [7:0] RST_REG = 8'h00;

  typedef enum logic [1:0] {TRIM_NORMAL, TRIM_UP, TRIM_DOWN} trim_sel_t;

  // Decode the margin trim pins into a value-set selection
  function automatic trim_sel_t trim_decode(input logic up_n, input logic dn_n);
    if (!up_n && dn_n) begin
      return TRIM_UP;
    end else if (up_n && !dn_n) begin
      return TRIM_DOWN;
    end
    return TRIM_NORMAL;
  endfunction : trim_decode

endpackage : gpio_special_pkg

// >>> src/gpio_special.sv
// Special functions of the general-purpose pins of a supply manager
`timescale 1ns/10ps
`default_nettype none
module gpio_special
  import gpio_special_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic REG_WE,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  input wire logic [2:0] PIN2_MODE,
  input wire logic [2:0] PIN3_MODE,
  input wire logic [2:0] PIN4_MODE,
  input wire logic [2:0] PIN5_MODE,
  input wire logic [2:0] PIN6_MODE,
  input wire logic MARGIN_CTRL,
  input wire logic [NUM_DAC-1:0] DAC_SWITCH_EN,
  input wire logic [NUM_CH-1:0] OV_VIOL,
  input wire logic [NUM_CH-1:0] UV_VIOL,
  input wire logic [NUM_CH-1:0] EW_VIOL,
  input wire logic SEQ_FAULT,
  input wire logic RESET_REQ,
  input wire logic WDOG_EXPIRED,
  input wire logic PIN2_IN,
  input wire logic PIN3_IN,
  input wire logic PIN4_IN,
  input wire logic PIN5_IN,
  input wire logic PIN6_IN,
  output logic PIN5_OUT,
  output logic PIN5_OE,
  output logic PIN6_OUT,
  output logic PIN6_OE,
  output logic COMBINED_FAULT,
  output logic RESET_START,
  output logic RESET_HOLD,
  output logic WATCHDOG_KICK,
  output logic ENABLES_OFF,
  output logic LOG_SAVE,
  output logic LOG_ALLOWED,
  output logic MARGIN_ACTIVE,
  output logic [1:0] TRIM_SET,
  output logic [NUM_DAC-1:0] DAC_SWITCH
);

  typedef struct packed {
    logic [7:0] a_sel;
    logic [7:0] a_cfg;
    logic [7:0] b_sel;
    logic [7:0] b_cfg;
    logic fault_a;
    logic fault_b;
    logic any_fault;
    logic reset_hold;
    logic pu_fault;
    logic save;
  } state_t;

  state_t st;
  state_t next_st;

  // ==========================================================
  // Fault evaluation
  logic [NUM_CH-1:0] sel_a;
  logic [NUM_CH-1:0] sel_b;
  logic hit_a;
  logic hit_b;
  logic margin_on;
  trim_sel_t trim;
  logic mr_low;

  assign sel_a = {st.a_cfg[CFG_HIGH_CH_MSB:0], st.a_sel}; // see R03
  assign sel_b = {st.b_cfg[CFG_HIGH_CH_MSB:0], st.b_sel}; // see R06

  // Any selected channel with any enabled violation type
  function automatic logic fault_hit(input logic [NUM_CH-1:0] sel, input logic [7:0] cfg,
                                     input logic [NUM_CH-1:0] ov, input logic [NUM_CH-1:0] uv,
                                     input logic [NUM_CH-1:0] ew);
    return |(sel & ((ov & {NUM_CH{cfg[CFG_OV_BIT]}})
                  | (uv & {NUM_CH{cfg[CFG_UV_BIT]}})
                  | (ew & {NUM_CH{cfg[CFG_EW_BIT]}}))); // see R02, R04
  endfunction : fault_hit

  assign hit_a = fault_hit(sel_a, st.a_cfg, OV_VIOL, UV_VIOL, EW_VIOL);
  assign hit_b = fault_hit(sel_b, st.b_cfg, OV_VIOL, UV_VIOL, EW_VIOL);

  // The hold pin only counts while the sixth pin is configured as margin input
  assign margin_on = ((PIN6_MODE == MODE_PIN6_MARGIN) && !PIN6_IN)
                   || MARGIN_CTRL; // see R12
  assign mr_low = (PIN4_MODE == MODE_SPECIAL) && !PIN4_IN;

  // Trim pins act only when both are configured for margining
  assign trim = ((PIN2_MODE == MODE_SPECIAL) && (PIN3_MODE == MODE_SPECIAL))
              ? trim_decode(PIN2_IN, PIN3_IN) : TRIM_NORMAL; // see R08, R09

  // ==========================================================
  // Next state
  always_comb begin
    next_st = st;
    next_st.save = 1'b0;
    if (REG_WE) begin
      unique case (REG_ADDR)
        OFS_FAULT_A_SEL: next_st.a_sel = REG_WDATA;
        OFS_FAULT_A_CFG: next_st.a_cfg = REG_WDATA;
        OFS_FAULT_B_SEL: next_st.b_sel = REG_WDATA;
        OFS_FAULT_B_CFG: next_st.b_cfg = REG_WDATA;
        default: next_st = next_st;
      endcase
    end
    // Frozen outputs keep their state; violations during margining are dropped
    if (!margin_on && trim == TRIM_NORMAL) begin // see R13, R10
      next_st.fault_a = hit_a; // see R18
      next_st.fault_b = hit_b; // see R18
      next_st.any_fault = |(OV_VIOL | UV_VIOL | EW_VIOL);
      next_st.reset_hold = mr_low || RESET_REQ; // see R15
      if (PIN6_MODE == MODE_SPECIAL && SEQ_FAULT && !st.pu_fault) begin
        next_st.pu_fault = 1'b1; // see R07
        next_st.save = 1'b1; // see R07
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      st <= '{a_sel: RST_REG, a_cfg: RST_REG, b_sel: RST_REG, b_cfg: RST_REG, default: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Register read
  always_comb begin
    unique case (REG_ADDR)
      OFS_FAULT_A_SEL: REG_RDATA = st.a_sel;
      OFS_FAULT_A_CFG: REG_RDATA = st.a_cfg;
      OFS_FAULT_B_SEL: REG_RDATA = st.b_sel;
      OFS_FAULT_B_CFG: REG_RDATA = st.b_cfg;
      default: REG_RDATA = 8'h00;
    endcase
  end

  // ==========================================================
  // Pin drivers
  logic a_level;
  logic b_level;
  logic p5_fault;
  logic p6_fault;

  // Polarity: asserted level equals the polarity bit
  assign a_level = st.a_cfg[CFG_POL_BIT] ? st.fault_a : !st.fault_a; // see R05
  assign b_level = st.b_cfg[CFG_POL_BIT] ? st.fault_b : !st.fault_b; // see R05
  assign p5_fault = (PIN5_MODE == MODE_FAULT_PP) || (PIN5_MODE == MODE_FAULT_OD); // see R01
  assign p6_fault = (PIN6_MODE == MODE_FAULT_PP) || (PIN6_MODE == MODE_FAULT_OD); // see R01

  always_comb begin
    PIN5_OUT = 1'b0;
    PIN5_OE = 1'b0;
    PIN6_OUT = 1'b0;
    PIN6_OE = 1'b0;
    if (p5_fault) begin
      PIN5_OUT = a_level;
      // Open drain only drives the low level
      PIN5_OE = (PIN5_MODE == MODE_FAULT_PP) || !a_level;
    end
    if (p6_fault) begin
      PIN6_OUT = b_level;
      PIN6_OE = (PIN6_MODE == MODE_FAULT_PP) || !b_level;
    end else if (PIN6_MODE == MODE_PIN6_WDOG) begin
      PIN6_OE = WDOG_EXPIRED; // see R16
    end else if (PIN6_MODE == MODE_SPECIAL) begin
      PIN6_OE = st.pu_fault; // see R07
    end
  end

  assign WATCHDOG_KICK = (PIN5_MODE == MODE_SPECIAL) && PIN5_IN; // see R17
  assign COMBINED_FAULT = st.any_fault;
  assign RESET_HOLD = st.reset_hold;
  assign RESET_START = st.reset_hold && !next_st.reset_hold; // see R15
  assign ENABLES_OFF = st.pu_fault; // see R07
  assign LOG_SAVE = st.save;
  // Trim up or down also enables margining, so logging closes then as well
  assign LOG_ALLOWED = !margin_on && (trim == TRIM_NORMAL); // see R13
  assign MARGIN_ACTIVE = margin_on || (trim != TRIM_NORMAL); // see R10
  assign TRIM_SET = trim;
  assign DAC_SWITCH = (trim != TRIM_NORMAL) ? {NUM_DAC{1'b1}} : DAC_SWITCH_EN; // see R10, R11

endmodule : gpio_special
`default_nettype wire

// >>> dv/rail_host_model.sv
// Behavioural host and supply rails facing the special pins
`timescale 1ns/10ps
`default_nettype none
module rail_host_model (
  input wire logic CLK,
  input wire logic hold_req,
  input wire logic [35:0] rail_set,
  output logic hold_n,
  output logic [35:0] rail
);
  // ==========
  // Hold drops at once and rails move a cycle later, so no excursion goes unheld
  assign hold_n = !hold_req;
  always_ff @(posedge CLK) begin
    rail <= rail_set;
  end
endmodule : rail_host_model
`default_nettype wire

// >>> dv/gpio_special_checker.sv
// Concurrent checks on the special-pin block
`timescale 1ns/10ps
`default_nettype none
module gpio_special_checker
  import gpio_special_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [2:0] PIN2_MODE,
  input wire logic [2:0] PIN3_MODE,
  input wire logic [2:0] PIN6_MODE,
  input wire logic MARGIN_CTRL,
  input wire logic [NUM_DAC-1:0] DAC_SWITCH_EN,
  input wire logic PIN2_IN,
  input wire logic PIN3_IN,
  input wire logic PIN6_IN,
  input wire logic COMBINED_FAULT,
  input wire logic RESET_HOLD,
  input wire logic LOG_ALLOWED,
  input wire logic MARGIN_ACTIVE,
  input wire logic [1:0] TRIM_SET,
  input wire logic [NUM_DAC-1:0] DAC_SWITCH
);
  // ==========
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  wire logic trim_on = PIN2_MODE == MODE_SPECIAL && PIN3_MODE == MODE_SPECIAL;
  wire logic pin_hold = PIN6_MODE == MODE_PIN6_MARGIN && !PIN6_IN;
  a_freeze_fault: assert property (MARGIN_ACTIVE |=> $stable(COMBINED_FAULT))
    else $error("fault state moved");
  a_freeze_reset: assert property (MARGIN_ACTIVE |=> $stable(RESET_HOLD))
    else $error("reset moved");
  a_no_log: assert property (MARGIN_ACTIVE |-> !LOG_ALLOWED) else $error("log open");
  a_hold_pin: assert property (pin_hold |-> MARGIN_ACTIVE) else $error("hold ignored");
  a_hold_ctrl: assert property (MARGIN_CTRL |-> MARGIN_ACTIVE) else $error("ctrl off");
  a_trim_up: assert property (trim_on && !PIN2_IN && PIN3_IN |->
    TRIM_SET == 2'h1 && &DAC_SWITCH && MARGIN_ACTIVE) else $error("up set wrong");
  a_trim_down: assert property (trim_on && PIN2_IN && !PIN3_IN |->
    TRIM_SET == 2'h2 && &DAC_SWITCH && MARGIN_ACTIVE) else $error("down set wrong");
  a_trim_norm: assert property (trim_on && PIN2_IN == PIN3_IN |->
    TRIM_SET == 2'h0 && DAC_SWITCH == DAC_SWITCH_EN) else $error("normal set wrong");
endmodule : gpio_special_checker
bind gpio_special gpio_special_checker sva (.CLK, .RST_N, .PIN2_MODE, .PIN3_MODE, .PIN6_MODE,
  .MARGIN_CTRL, .DAC_SWITCH_EN, .PIN2_IN, .PIN3_IN, .PIN6_IN, .COMBINED_FAULT, .RESET_HOLD,
  .LOG_ALLOWED, .MARGIN_ACTIVE, .TRIM_SET, .DAC_SWITCH);
`default_nettype wire

// >>> dv/gpio_special_tb_top.sv
// Self-checking bench for the special-pin block
`timescale 1ns/10ps
`default_nettype none
module gpio_special_tb_top import gpio_special_pkg::*;;
  logic CLK = 1'b0, RST_N = 1'b0, REG_WE = 1'b0, MARGIN_CTRL = 1'b0, WDOG_EXPIRED = 1'b0;
  logic SEQ_FAULT = 1'b0;
  logic hold_req = 1'b0, PIN2_IN = 1'b1, PIN3_IN = 1'b1, PIN4_IN = 1'b1, PIN5_IN = 1'b0;
  logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00, REG_RDATA;
  logic [2:0] PIN2_MODE = 3'h0, PIN3_MODE = 3'h0, PIN4_MODE = 3'h0;
  logic [2:0] PIN5_MODE = MODE_FAULT_PP, PIN6_MODE = MODE_FAULT_PP;
  logic [NUM_DAC-1:0] DAC_SWITCH_EN = 12'h000, DAC_SWITCH;
  logic [35:0] rail_set = 36'h000000000;
  wire logic [35:0] rail;
  wire logic PIN6_IN;
  logic PIN5_OUT, PIN5_OE, PIN6_OUT, PIN6_OE, COMBINED_FAULT, RESET_START, RESET_HOLD;
  logic WATCHDOG_KICK, ENABLES_OFF, LOG_SAVE, LOG_ALLOWED, MARGIN_ACTIVE;
  logic [1:0] TRIM_SET;
  int err_count = 0, total_checks = 0;
  gpio_special DUT (.CLK, .RST_N, .REG_WE, .REG_ADDR, .REG_WDATA, .REG_RDATA, .PIN2_MODE,
    .PIN3_MODE, .PIN4_MODE, .PIN5_MODE, .PIN6_MODE, .MARGIN_CTRL, .DAC_SWITCH_EN,
    .OV_VIOL(rail[35:24]), .UV_VIOL(rail[23:12]), .EW_VIOL(rail[11:0]), .SEQ_FAULT,
    .RESET_REQ(1'b0), .WDOG_EXPIRED, .PIN2_IN, .PIN3_IN, .PIN4_IN, .PIN5_IN, .PIN6_IN,
    .PIN5_OUT, .PIN5_OE, .PIN6_OUT, .PIN6_OE, .COMBINED_FAULT, .RESET_START, .RESET_HOLD,
    .WATCHDOG_KICK, .ENABLES_OFF, .LOG_SAVE, .LOG_ALLOWED, .MARGIN_ACTIVE, .TRIM_SET, .DAC_SWITCH);
  rail_host_model partner (.CLK, .hold_req, .rail_set, .hold_n(PIN6_IN), .rail);
  initial forever #4 CLK = ~CLK;
  // ==========
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK);
    {REG_WE, REG_ADDR, REG_WDATA} <= {1'b1, a, d};
    @(posedge CLK);
    REG_WE <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge CLK);
    REG_ADDR <= a;
    #1 chk(REG_RDATA, exp);
  endtask : rd
  // Level v on threshold type k, level w on the other two types
  task automatic viol(input int k, input logic [11:0] v, input logic [11:0] w);
    @(posedge CLK);
    rail_set <= {k == 0 ? v : w, k == 1 ? v : w, k == 2 ? v : w};
    tick(3);
  endtask : viol
  // ==========
  task automatic t_regs;
    for (logic [7:0] a = 8'h15; a < 8'h1A; a++) rd(a, 8'h00);
    wr(8'h19, 8'hFF);
    rd(8'h19, 8'h00);
    chk({PIN5_OE, PIN5_OUT}, 2'h3);
  endtask : t_regs
  task automatic t_types;
    for (int k = 0; k < 3; k++) begin
      wr(OFS_FAULT_A_SEL, 8'h01);
      wr(OFS_FAULT_A_CFG, 8'h10 << k);
      viol(k, 12'h002, 12'h001);
      chk(PIN5_OUT, 1'b1);
      viol(k, 12'h001, 12'h000);
      chk({PIN5_OUT, COMBINED_FAULT}, 2'h1);
      viol(k, 12'h000, 12'h000);
      chk(PIN5_OUT, 1'b1);
    end
  endtask : t_types
  task automatic t_fault_b;
    wr(OFS_FAULT_B_SEL, 8'h80);
    wr(OFS_FAULT_B_CFG, 8'h98);
    rd(OFS_FAULT_B_CFG, 8'h98);
    chk({PIN6_OE, PIN6_OUT}, 2'h2);
    viol(0, 12'h800, 12'h000);
    chk(PIN6_OUT, 1'b1);
    viol(0, 12'h080, 12'h000);
    chk(PIN6_OUT, 1'b1);
  endtask : t_fault_b
  task automatic t_margin;
    @(posedge CLK);
    MARGIN_CTRL <= 1'b1;
    viol(0, 12'h000, 12'h000);
    chk({PIN6_OUT, COMBINED_FAULT, LOG_ALLOWED}, 3'h6);
    @(posedge CLK);
    MARGIN_CTRL <= 1'b0;
    tick(2);
    chk({PIN6_OUT, COMBINED_FAULT}, 2'h0);
    @(posedge CLK);
    {PIN6_MODE, hold_req} <= {MODE_PIN6_MARGIN, 1'b1};
    tick(1);
    chk(MARGIN_ACTIVE, 1'b1);
  endtask : t_margin
  task automatic t_trim;
    @(posedge CLK);
    {hold_req, PIN2_MODE, PIN3_MODE} <= {1'b0, MODE_SPECIAL, MODE_SPECIAL};
    DAC_SWITCH_EN <= 12'h5A3;
    for (int i = 0; i < 4; i++) begin
      @(posedge CLK);
      {PIN2_IN, PIN3_IN} <= 2'(i);
      tick(1);
      chk(TRIM_SET, i == 1 ? 2'h1 : i == 2 ? 2'h2 : 2'h0);
      chk(DAC_SWITCH, i == 1 || i == 2 ? 12'hFFF : 12'h5A3);
    end
  endtask : t_trim
  task automatic t_pins;
    int n;
    @(posedge CLK);
    {PIN5_MODE, PIN5_IN, PIN6_MODE, WDOG_EXPIRED} <= {MODE_SPECIAL, 1'b1, MODE_PIN6_WDOG, 1'b1};
    {PIN4_MODE, PIN4_IN} <= {MODE_SPECIAL, 1'b0};
    tick(2);
    chk({WATCHDOG_KICK, PIN6_OE, PIN6_OUT, RESET_HOLD}, 4'hD);
    @(posedge CLK);
    PIN4_IN <= 1'b1;
    #1;
    n = 0;
    while (RESET_START !== 1'b1 && n < 8) begin
      tick(1);
      n++;
    end
    // The start pulse stands in the last cycle of the hold
    chk({n < 8, RESET_HOLD}, 2'h3);
    if (n == 8) tally_and_finish();
    tick(1);
    chk({RESET_START, RESET_HOLD}, 2'h0);
  endtask : t_pins
  task automatic t_powerup;
    @(posedge CLK);
    {PIN6_MODE, SEQ_FAULT} <= {MODE_SPECIAL, 1'b1};
    tick(1);
    chk({LOG_SAVE, ENABLES_OFF, PIN6_OE, PIN6_OUT}, 4'hE);
    tick(1);
    chk({LOG_SAVE, ENABLES_OFF, PIN6_OE}, 3'h3);
  endtask : t_powerup
  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (20) @(posedge CLK);
    RST_N <= 1'b1;
    t_regs();
    t_types();
    t_fault_b();
    t_margin();
    t_trim();
    t_pins();
    t_powerup();
    tally_and_finish();
  end
endmodule : gpio_special_tb_top
`default_nettype wire
